// ===== shared/oss_pkg.sv
// Shared constants and types for the output safety supervisor.
// Assumes a 50 MHz clock and a 16-bit register port.
package oss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;
  localparam int NUM_AO = 2;
  localparam int DO_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_TIME_NS = 1000000;
  localparam int CYC_PER_MS_DEF = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int MOD_WDT_TIME_MS = 100;
  localparam int MOD_WDT_CYC_DEF = MOD_WDT_TIME_MS * CYC_PER_MS_DEF;
  localparam logic [7:0] BLINK_TIME_MS = 8'hFA;

  ////////////////////////////////////////////////////////////////////////////
  // Register word addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] HWDT_PERIOD_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] CMD_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] DO_CMD_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] AO_CMD_BASE = 4'h5;
  localparam logic [ADDR_W-1:0] ALARM_HI_ADDR = 4'h7;
  localparam logic [ADDR_W-1:0] ALARM_LO_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] PWRON_DO_ADDR = 4'h9;
  localparam logic [ADDR_W-1:0] SAFE_DO_ADDR = 4'hA;
  localparam logic [ADDR_W-1:0] PWRON_AO_BASE = 4'hB;
  localparam logic [ADDR_W-1:0] SAFE_AO_BASE = 4'hD;
  localparam logic [ADDR_W-1:0] AI_VALUE_ADDR = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [DATA_W-1:0] HWDT_PERIOD_RST = 16'h03E8;
  localparam logic [DO_W-1:0] PWRON_DO_RST = 8'h00;
  localparam logic [DO_W-1:0] SAFE_DO_RST = 8'h00;
  localparam logic [DATA_W-1:0] PWRON_AO_RST = 16'h0000;
  localparam logic [DATA_W-1:0] SAFE_AO_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ALARM_HI_RST = 16'h7FFF;
  localparam logic [DATA_W-1:0] ALARM_LO_RST = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // Commands and answers
  localparam logic [CODE_W-1:0] CMD_READ_STATUS = 8'h00;
  localparam logic [CODE_W-1:0] CMD_CLEAR_TIMEOUT = 8'h01;
  localparam logic [CODE_W-1:0] CMD_RESET_QUERY = 8'h05;
  localparam logic [CODE_W-1:0] CMD_ALARM_CLEAR = 8'h06;
  localparam logic [CODE_W-1:0] STATUS_TIMEOUT = 8'h04;
  localparam logic [CODE_W-1:0] STATUS_NORMAL = 8'h00;
  localparam logic [CODE_W-1:0] RSTQ_SET = 8'h01;
  localparam logic [CODE_W-1:0] RSTQ_CLEAR = 8'h00;
  localparam logic [CODE_W-1:0] RESP_SUCCESS = 8'h3E;
  localparam logic [CODE_W-1:0] RESP_IGNORED = 8'h21;
  localparam logic [CODE_W-1:0] RESP_UNKNOWN = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Data encoding and alarm ownership
  localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;
  localparam logic [DO_W-1:0] ALARM_DO_MASK = 8'h03;
  localparam int LOW_ALARM_BIT = 0;
  localparam int HIGH_ALARM_BIT = 1;

  typedef struct packed {
    logic [11:0] rsvd;
    logic rangeUnsigned;
    logic alarmLatch;
    logic alarmEn;
    logic hostWdtEn;
  } oss_ctrl_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic highAlarm;
    logic lowAlarm;
    logic ledOn;
    logic resetStatus;
    logic timeoutFlag;
  } oss_status_t;

endpackage : oss_pkg

// ===== rtl/oss_supervisor.sv
// Output safety supervisor: power-on/safe outputs, two watchdogs,
// reset status, limit alarm on two outputs.
// Assumes an external store keeps the timeout flag.
//
// Behaviour
// - Reboot loads power-on values, safe values when flagged
// - Commands accepted after reboot
// - Host timeout: flag, safe values
// - Flagged: drop output commands, blink lamp
// - Status answers 04 when flagged
// - Clear command drops flag
// - Reset status set on every reboot
// - Reset query reports, then clears
// - Watchdog reboots stalled module
// - Current ranges: unsigned codes
// - Other ranges: signed codes
// - Alarm: output0 low, output1 high
// - Alarm: commands to outputs 0 and 1 ignored
// - Momentary: high while above limit
// - Momentary: low while below limit
// - Momentary: alarm drops inside limits
// - Latch: alarm stays after crossing
// - Latch cleared by command or reset
// - Flag non-volatile, safe at power-on
// - Analog command: ignored or success
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps

module oss_supervisor
  import oss_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF,
  parameter int unsigned MOD_WDT_CYCLES = MOD_WDT_CYC_DEF
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  // Host link activity
  input wire logic hostMsgValid,
  // Module health
  input wire logic coreAlive,
  // Non-volatile timeout flag copy
  input wire logic nvTimeoutIn,
  output logic nvTimeoutOut,
  // Analog input and alarm reset
  input wire logic [DATA_W-1:0] adcRaw,
  input wire logic alarmManualClr,
  // Outputs
  output logic [NUM_AO-1:0][DATA_W-1:0] aoOut,
  output logic [DO_W-1:0] doOut,
  output logic statusLed,
  output logic moduleReboot
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared limit compare
  function automatic logic exceeds(input logic [DATA_W-1:0] a,
                                   input logic [DATA_W-1:0] b,
                                   input logic unsignedMode);
    if (unsignedMode)
    begin
      return a > b;
    end
    return $signed(a) > $signed(b);
  endfunction : exceeds

  oss_ctrl_t ctrl_reg;
  logic [DATA_W-1:0] hwdtPeriod_reg;
  logic [DATA_W-1:0] alarmHi_reg;
  logic [DATA_W-1:0] alarmLo_reg;
  logic [DO_W-1:0] pwronDo_reg;
  logic [DO_W-1:0] safeDo_reg;
  logic [DATA_W-1:0] pwronAo_reg [NUM_AO];
  logic [DATA_W-1:0] safeAo_reg [NUM_AO];
  logic [DATA_W-1:0] aoCmd_reg [NUM_AO];
  logic [DO_W-1:0] doCmd_reg;
  logic [DATA_W-1:0] analogInputValue_reg;
  logic hostTimeoutFlag_reg;
  logic resetStatus_reg;
  logic lowAlarm_reg;
  logic highAlarm_reg;
  logic [CODE_W-1:0] cmdResult_reg;
  logic [31:0] msCnt_reg;
  logic msTick;
  logic [DATA_W-1:0] hostMs_reg;
  logic [DATA_W-1:0] hostMsNext;
  logic hostFire;
  logic [31:0] modCnt_reg;
  logic modFire;
  logic [7:0] blinkCnt_reg;
  logic blink_reg;
  logic [DATA_W-1:0] rdMux;
  logic cmdWr;
  logic [CODE_W-1:0] cmdCode;
  logic clrTimeoutCmd;
  logic alarmClr;
  logic aboveHigh;
  logic belowLow;
  logic [DO_W-1:0] alarmBits;
  oss_status_t status;

  assign cmdWr = regWr && (regAddr == CMD_ADDR);
  assign cmdCode = regWdata[CODE_W-1:0];
  assign clrTimeoutCmd = cmdWr && (cmdCode == CMD_CLEAR_TIMEOUT);
  assign alarmClr = (cmdWr && (cmdCode == CMD_ALARM_CLEAR)) || alarmManualClr;

  ////////////////////////////////////////////////////////////////////////////
  // Config registers; a reboot keeps them
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= '0;
      hwdtPeriod_reg <= HWDT_PERIOD_RST;
      alarmHi_reg <= ALARM_HI_RST;
      alarmLo_reg <= ALARM_LO_RST;
      pwronDo_reg <= PWRON_DO_RST;
      safeDo_reg <= SAFE_DO_RST;
      for (int i = 0; i < NUM_AO; i++)
      begin
        pwronAo_reg[i] <= PWRON_AO_RST;
        safeAo_reg[i] <= SAFE_AO_RST;
      end
    end
    else if (ce && regWr)
    begin
      unique case (regAddr)
        CTRL_ADDR: ctrl_reg <= {12'h000, regWdata[3:0]};
        HWDT_PERIOD_ADDR: hwdtPeriod_reg <= regWdata;
        ALARM_HI_ADDR: alarmHi_reg <= regWdata;
        ALARM_LO_ADDR: alarmLo_reg <= regWdata;
        PWRON_DO_ADDR: pwronDo_reg <= regWdata[DO_W-1:0];
        SAFE_DO_ADDR: safeDo_reg <= regWdata[DO_W-1:0];
        default:
        begin
          for (int i = 0; i < NUM_AO; i++)
          begin
            if (regAddr == PWRON_AO_BASE + ADDR_W'(i))
            begin
              pwronAo_reg[i] <= regWdata;
            end
            if (regAddr == SAFE_AO_BASE + ADDR_W'(i))
            begin
              safeAo_reg[i] <= regWdata;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base
  assign msTick = (msCnt_reg == 32'(CYC_PER_MS - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      msCnt_reg <= '0;
    end
    else if (ce)
    begin
      msCnt_reg <= msTick ? '0 : msCnt_reg + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host watchdog; a zero period never fires
  assign hostMsNext = hostMs_reg + 16'h0001;
  assign hostFire = ctrl_reg.hostWdtEn && msTick && !hostTimeoutFlag_reg
                    && (hwdtPeriod_reg != '0) && (hostMsNext >= hwdtPeriod_reg);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hostMs_reg <= '0;
    end
    else if (ce)
    begin
      if (!ctrl_reg.hostWdtEn || hostMsgValid || hostFire || modFire)
      begin
        hostMs_reg <= '0;
      end
      else if (msTick && (hostMs_reg != '1))
      begin
        hostMs_reg <= hostMsNext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Module watchdog; a stalled core forces a reboot
  assign modFire = (modCnt_reg == 32'(MOD_WDT_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      modCnt_reg <= '0;
      moduleReboot <= 1'b0;
    end
    else if (ce)
    begin
      modCnt_reg <= (coreAlive || modFire) ? '0 : modCnt_reg + 32'h00000001;
      moduleReboot <= modFire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout flag; loaded from the store, set beats clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hostTimeoutFlag_reg <= nvTimeoutIn;
    end
    else if (ce)
    begin
      if (hostFire)
      begin
        hostTimeoutFlag_reg <= 1'b1;
      end
      else if (clrTimeoutCmd)
      begin
        hostTimeoutFlag_reg <= 1'b0;
      end
    end
  end

  assign nvTimeoutOut = hostTimeoutFlag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Reset status; a reboot beats the query
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      resetStatus_reg <= 1'b1;
    end
    else if (ce)
    begin
      if (modFire)
      begin
        resetStatus_reg <= 1'b1;
      end
      else if (cmdWr && (cmdCode == CMD_RESET_QUERY))
      begin
        resetStatus_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command answers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cmdResult_reg <= STATUS_NORMAL;
    end
    else if (ce && regWr)
    begin
      if (cmdWr)
      begin
        unique case (cmdCode)
          CMD_READ_STATUS:
            cmdResult_reg <= hostTimeoutFlag_reg ? STATUS_TIMEOUT : STATUS_NORMAL;
          CMD_CLEAR_TIMEOUT: cmdResult_reg <= RESP_SUCCESS;
          CMD_RESET_QUERY:
            cmdResult_reg <= resetStatus_reg ? RSTQ_SET : RSTQ_CLEAR;
          CMD_ALARM_CLEAR: cmdResult_reg <= RESP_SUCCESS;
          default: cmdResult_reg <= RESP_UNKNOWN;
        endcase
      end
      else if ((regAddr == DO_CMD_ADDR) || (regAddr == AO_CMD_BASE)
               || (regAddr == AO_CMD_BASE + ADDR_W'(1)))
      begin
        cmdResult_reg <= hostTimeoutFlag_reg ? RESP_IGNORED : RESP_SUCCESS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commanded outputs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      doCmd_reg <= nvTimeoutIn ? SAFE_DO_RST : PWRON_DO_RST;
      for (int i = 0; i < NUM_AO; i++)
      begin
        aoCmd_reg[i] <= nvTimeoutIn ? SAFE_AO_RST : PWRON_AO_RST;
      end
    end
    else if (ce)
    begin
      if (modFire || hostFire)
      begin
        // Safe values stay until the host writes anew
        doCmd_reg <= (hostTimeoutFlag_reg || hostFire) ? safeDo_reg : pwronDo_reg;
        for (int i = 0; i < NUM_AO; i++)
        begin
          aoCmd_reg[i] <= (hostTimeoutFlag_reg || hostFire) ? safeAo_reg[i]
                                                           : pwronAo_reg[i];
        end
      end
      else if (regWr && !hostTimeoutFlag_reg)
      begin
        if (regAddr == DO_CMD_ADDR)
        begin
          doCmd_reg <= ctrl_reg.alarmEn
                       ? ((regWdata[DO_W-1:0] & ~ALARM_DO_MASK) | (doCmd_reg & ALARM_DO_MASK))
                       : regWdata[DO_W-1:0];
        end
        for (int i = 0; i < NUM_AO; i++)
        begin
          if (regAddr == AO_CMD_BASE + ADDR_W'(i))
          begin
            aoCmd_reg[i] <= regWdata;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset-binary raw value to range code
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      analogInputValue_reg <= '0;
    end
    else if (ce)
    begin
      analogInputValue_reg <= ctrl_reg.rangeUnsigned ? adcRaw
                                                     : (adcRaw ^ SIGN_FLIP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit alarm, a cycle behind the encoding
  assign aboveHigh = exceeds(analogInputValue_reg, alarmHi_reg, ctrl_reg.rangeUnsigned);
  assign belowLow = exceeds(alarmLo_reg, analogInputValue_reg, ctrl_reg.rangeUnsigned);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lowAlarm_reg <= 1'b0;
      highAlarm_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!ctrl_reg.alarmEn || modFire)
      begin
        lowAlarm_reg <= 1'b0;
        highAlarm_reg <= 1'b0;
      end
      else if (ctrl_reg.alarmLatch)
      begin
        // Crossing beats clear
        if (belowLow)
        begin
          lowAlarm_reg <= 1'b1;
        end
        else if (alarmClr)
        begin
          lowAlarm_reg <= 1'b0;
        end
        if (aboveHigh)
        begin
          highAlarm_reg <= 1'b1;
        end
        else if (alarmClr)
        begin
          highAlarm_reg <= 1'b0;
        end
      end
      else
      begin
        lowAlarm_reg <= belowLow;
        highAlarm_reg <= aboveHigh;
      end
    end
  end

  always_comb
  begin
    alarmBits = '0;
    alarmBits[LOW_ALARM_BIT] = lowAlarm_reg;
    alarmBits[HIGH_ALARM_BIT] = highAlarm_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; timeout has the last word
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      doOut <= nvTimeoutIn ? SAFE_DO_RST : PWRON_DO_RST;
      for (int i = 0; i < NUM_AO; i++)
      begin
        aoOut[i] <= nvTimeoutIn ? SAFE_AO_RST : PWRON_AO_RST;
      end
    end
    else if (ce)
    begin
      if (hostTimeoutFlag_reg)
      begin
        doOut <= safeDo_reg;
      end
      else if (ctrl_reg.alarmEn)
      begin
        doOut <= (doCmd_reg & ~ALARM_DO_MASK) | alarmBits;
      end
      else
      begin
        doOut <= doCmd_reg;
      end
      for (int i = 0; i < NUM_AO; i++)
      begin
        aoOut[i] <= hostTimeoutFlag_reg ? safeAo_reg[i] : aoCmd_reg[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp: steady on, blinking while timed out
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      blinkCnt_reg <= '0;
      blink_reg <= 1'b0;
      statusLed <= 1'b1;
    end
    else if (ce)
    begin
      if (!hostTimeoutFlag_reg)
      begin
        blinkCnt_reg <= '0;
        blink_reg <= 1'b0;
      end
      else if (msTick)
      begin
        if (blinkCnt_reg == BLINK_TIME_MS - 8'h01)
        begin
          blinkCnt_reg <= '0;
          blink_reg <= ~blink_reg;
        end
        else
        begin
          blinkCnt_reg <= blinkCnt_reg + 8'h01;
        end
      end
      statusLed <= hostTimeoutFlag_reg ? blink_reg : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back; data stand one cycle after the strobe
  always_comb
  begin
    status = '0;
    status.timeoutFlag = hostTimeoutFlag_reg;
    status.resetStatus = resetStatus_reg;
    status.ledOn = statusLed;
    status.lowAlarm = lowAlarm_reg;
    status.highAlarm = highAlarm_reg;
    unique case (regAddr)
      CTRL_ADDR: rdMux = ctrl_reg;
      HWDT_PERIOD_ADDR: rdMux = hwdtPeriod_reg;
      CMD_ADDR: rdMux = {8'h00, cmdResult_reg};
      STATUS_ADDR: rdMux = status;
      DO_CMD_ADDR: rdMux = {8'h00, doOut};
      AO_CMD_BASE: rdMux = aoOut[0];
      ALARM_HI_ADDR: rdMux = alarmHi_reg;
      ALARM_LO_ADDR: rdMux = alarmLo_reg;
      PWRON_DO_ADDR: rdMux = {8'h00, pwronDo_reg};
      SAFE_DO_ADDR: rdMux = {8'h00, safeDo_reg};
      PWRON_AO_BASE: rdMux = pwronAo_reg[0];
      SAFE_AO_BASE: rdMux = safeAo_reg[0];
      AI_VALUE_ADDR: rdMux = analogInputValue_reg;
      AO_CMD_BASE + 4'h1: rdMux = aoOut[1];
      PWRON_AO_BASE + 4'h1: rdMux = pwronAo_reg[1];
      SAFE_AO_BASE + 4'h1: rdMux = safeAo_reg[1];
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      regRdata <= '0;
    end
    else if (ce)
    begin
      regRdata <= regRd ? rdMux : '0;
    end
  end

endmodule : oss_supervisor

// ===== tb/oss_host_model.sv
// Host partner: link activity and core heartbeat pulses.
// Assumes the bench gates each stream.
`timescale 1ns/10ps
module oss_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Stream gates
  input wire logic msgEn,
  input wire logic aliveEn,
  // Pulses
  output logic hostMsgValid,
  output logic coreAlive
);
  logic [1:0] phase;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end
  // Sparse pulses, as from a real host
  always_ff @(posedge clk)
  begin
    hostMsgValid <= rst_b && msgEn && (phase == 2'h0);
    coreAlive <= rst_b && aliveEn && (phase == 2'h2);
  end
endmodule : oss_host_model

// ===== tb/oss_properties.sv
// Port-level checks of the output safety supervisor.
// Assumes it sees every write, to shadow the config.
`timescale 1ns/10ps
module oss_properties
  import oss_pkg::*;
#(
  parameter int unsigned MOD_WDT_CYCLES = MOD_WDT_CYC_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdata,
  // Health, flag, alarm
  input wire logic coreAlive,
  input wire logic nvTimeoutOut,
  input wire logic [DATA_W-1:0] adcRaw,
  input wire logic alarmManualClr,
  // Outputs
  input wire logic [NUM_AO-1:0][DATA_W-1:0] aoOut,
  input wire logic [DO_W-1:0] doOut,
  input wire logic moduleReboot
);
  logic [3:0] ctl;
  logic [DATA_W-1:0] hiLim;
  logic [DATA_W-1:0] loLim;
  logic [DATA_W-1:0] enc;
  logic [DO_W-1:0] pwrDo;
  logic [DO_W-1:0] safeDo;
  logic hiHit;
  logic loHit;
  int unsigned idle;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctl <= 4'h0;
      hiLim <= ALARM_HI_RST;
      loLim <= ALARM_LO_RST;
      pwrDo <= PWRON_DO_RST;
      safeDo <= SAFE_DO_RST;
    end
    else if (regWr && ce)
    begin
      case (regAddr)
        CTRL_ADDR: ctl <= regWdata[3:0];
        ALARM_HI_ADDR: hiLim <= regWdata;
        ALARM_LO_ADDR: loLim <= regWdata;
        PWRON_DO_ADDR: pwrDo <= regWdata[DO_W-1:0];
        SAFE_DO_ADDR: safeDo <= regWdata[DO_W-1:0];
        default: ;
      endcase
    end
  end
  // Lags the design's count, hence slack
  always_ff @(posedge clk)
  begin
    if (!rst_b || coreAlive || moduleReboot)
      idle <= 0;
    else if (ce)
      idle <= idle + 1;
  end
  assign enc = ctl[3] ? adcRaw : adcRaw ^ SIGN_FLIP;
  assign hiHit = ctl[3] ? (enc > hiLim) : ($signed(enc) > $signed(hiLim));
  assign loHit = ctl[3] ? (enc < loLim) : ($signed(enc) < $signed(loLim));
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_quiet;
    (ce && !regWr && !moduleReboot && !nvTimeoutOut && !alarmManualClr && $stable(adcRaw))[*5];
  endsequence
  property p_rd_idle;
    ce && !regRd |=> regRdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left standing");
  property p_wdt;
    moduleReboot |-> idle + 4 >= MOD_WDT_CYCLES;
  endproperty
  a_wdt: assert property (p_wdt) else $error("reboot without stall");
  property p_boot_load;
    moduleReboot && !nvTimeoutOut && !ctl[1] |-> ##[0:2] doOut == pwrDo;
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("no power-on value");
  property p_safe_load;
    $rose(nvTimeoutOut) |-> ##[1:3] doOut == safeDo;
  endproperty
  a_safe_load: assert property (p_safe_load) else $error("no safe value");
  property p_frozen;
    nvTimeoutOut [*5] |-> $stable(doOut) && $stable(aoOut);
  endproperty
  a_frozen: assert property (p_frozen) else $error("output moved in timeout");
  property p_do_wr;
    regWr && ce && regAddr == DO_CMD_ADDR && !nvTimeoutOut && !ctl[1]
      |-> ##2 doOut == $past(regWdata[DO_W-1:0], 2);
  endproperty
  a_do_wr: assert property (p_do_wr) else $error("output write lost");
  property p_mom;
    s_quiet ##0 (ctl[1] && !ctl[2]) |-> doOut[1:0] == {hiHit, loHit};
  endproperty
  a_mom: assert property (p_mom) else $error("momentary alarm wrong");
  property p_latch;
    ctl[1] && ctl[2] && doOut[1] && ce && !regWr && !$past(regWr) && !alarmManualClr
      && !$past(alarmManualClr) && !nvTimeoutOut && !moduleReboot |=> doOut[1];
  endproperty
  a_latch: assert property (p_latch) else $error("latched alarm dropped");
endmodule : oss_properties

bind oss_supervisor oss_properties #(.MOD_WDT_CYCLES(MOD_WDT_CYCLES)) i_props (
  .clk(clk), .rst_b(rst_b), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .coreAlive(coreAlive),
  .nvTimeoutOut(nvTimeoutOut), .adcRaw(adcRaw), .alarmManualClr(alarmManualClr),
  .aoOut(aoOut), .doOut(doOut), .moduleReboot(moduleReboot)
);

// ===== tb/tb_top.sv
// Self-checking bench for the output safety supervisor.
// Assumes 10 cycles per ms, 200-cycle module watchdog.
`timescale 1ns/10ps
module tb_top;
  import oss_pkg::*;
  typedef struct packed {logic [3:0] ctl; logic [15:0] adc; logic [1:0] al;} oss_row_t;
  logic clk, rst_b, ce, regWr, regRd, nvTimeoutIn, alarmManualClr, nvTimeoutOut;
  logic statusLed, moduleReboot, hostMsgValid, coreAlive, msgEn, aliveEn;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, adcRaw, v;
  logic [NUM_AO-1:0][DATA_W-1:0] aoOut;
  logic [DO_W-1:0] doOut;
  int n_fail, check_count;
  // Limits 1000, F000; equality must not trip
  oss_row_t rows [9] = '{'{4'h2, 16'h9001, 2'b10}, '{4'h2, 16'h9000, 2'b00},
    '{4'h2, 16'h7000, 2'b00}, '{4'h2, 16'h6FFF, 2'b01}, '{4'h2, 16'h0000, 2'b01},
    '{4'h2, 16'hFFFF, 2'b10}, '{4'hA, 16'h0800, 2'b01}, '{4'hA, 16'hF800, 2'b10},
    '{4'hA, 16'h8000, 2'b11}};
  oss_supervisor #(.CYC_PER_MS(10), .MOD_WDT_CYCLES(200)) i_dut (.clk(clk), .rst_b(rst_b),
    .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .hostMsgValid(hostMsgValid), .coreAlive(coreAlive),
    .nvTimeoutIn(nvTimeoutIn), .nvTimeoutOut(nvTimeoutOut), .adcRaw(adcRaw),
    .alarmManualClr(alarmManualClr), .aoOut(aoOut), .doOut(doOut),
    .statusLed(statusLed), .moduleReboot(moduleReboot));
  oss_host_model i_host (.clk(clk), .rst_b(rst_b), .msgEn(msgEn), .aliveEn(aliveEn),
    .hostMsgValid(hostMsgValid), .coreAlive(coreAlive));
  ////////////////////////////////////////////////////////////////////////////
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge clk);
  endtask : rd
  task cmd(input logic [CODE_W-1:0] c);
    wr(CMD_ADDR, 16'(c));
    rd(CMD_ADDR, v);
  endtask : cmd
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask : chk
  task conclude;
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Run is some 3000 cycles; the limit is 20000 cycles
  initial
  begin
    #400000;
    n_fail++;
    conclude();
  end
  initial
  begin
    {rst_b, regWr, regRd, nvTimeoutIn, alarmManualClr, regAddr, regWdata, adcRaw} = '0;
    {ce, msgEn, aliveEn} = 3'b111;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(STATUS_ADDR, v);
    chk("status", v, 16'h0006);
    cmd(CMD_RESET_QUERY);
    chk("rstq", v, 16'(RSTQ_SET));
    cmd(CMD_RESET_QUERY);
    chk("rstq2", v, 16'(RSTQ_CLEAR));
    wr(DO_CMD_ADDR, 16'h00A5);
    wr(AO_CMD_BASE, 16'h4321);
    rd(CMD_ADDR, v);
    chk("aoresp", v, 16'(RESP_SUCCESS));
    chk("do", 16'(doOut), 16'h00A5);
    chk("ao", aoOut[0], 16'h4321);
    wr(ALARM_HI_ADDR, 16'h1000);
    wr(ALARM_LO_ADDR, 16'hF000);
    foreach (rows[i])
    begin
      wr(CTRL_ADDR, 16'(rows[i].ctl));
      adcRaw <= rows[i].adc;
      repeat (5) @(posedge clk);
      chk("alarm", 16'(doOut[1:0]), 16'(rows[i].al));
    end
    wr(DO_CMD_ADDR, 16'h00FC);
    repeat (2) @(posedge clk);
    chk("doalarm", 16'(doOut), 16'h00FF);
    wr(CTRL_ADDR, 16'h0006);
    cmd(CMD_ALARM_CLEAR);
    adcRaw <= 16'h9001;
    repeat (5) @(posedge clk);
    adcRaw <= 16'h8000;
    repeat (5) @(posedge clk);
    chk("latch", 16'(doOut[1:0]), 16'h0002);
    cmd(CMD_ALARM_CLEAR);
    repeat (3) @(posedge clk);
    chk("alclr", 16'(doOut[1:0]), 16'h0000);
    adcRaw <= 16'h6FFF;
    repeat (5) @(posedge clk);
    rd(AI_VALUE_ADDR, v);
    chk("aineg", 16'($signed(v) * 1000 / 32768), 16'hFF83);
    adcRaw <= 16'h8000;
    @(posedge clk);
    alarmManualClr <= 1'b1;
    @(posedge clk);
    alarmManualClr <= 1'b0;
    repeat (3) @(posedge clk);
    chk("manclr", 16'(doOut[1:0]), 16'h0000);
    wr(CTRL_ADDR, 16'h0000);
    wr(SAFE_DO_ADDR, 16'h005A);
    wr(SAFE_AO_BASE, 16'h1234);
    wr(HWDT_PERIOD_ADDR, 16'h0001);
    wr(CTRL_ADDR, 16'h0001);
    msgEn <= 1'b0;
    for (int k = 0; k < 200 && nvTimeoutOut !== 1'b1; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("safedo", 16'(doOut), 16'h005A);
    chk("safeao", aoOut[0], 16'h1234);
    cmd(CMD_READ_STATUS);
    chk("wdstat", v, 16'(STATUS_TIMEOUT));
    wr(DO_CMD_ADDR, 16'h00FF);
    rd(CMD_ADDR, v);
    chk("doresp", v, 16'(RESP_IGNORED));
    wr(AO_CMD_BASE, 16'h0777);
    rd(CMD_ADDR, v);
    chk("aoign", v, 16'(RESP_IGNORED));
    chk("dohold", 16'(doOut), 16'h005A);
    chk("ledoff", 16'(statusLed), 16'h0000);
    for (int k = 0; k < 3000 && statusLed !== 1'b1; k++) @(posedge clk);
    chk("blink", 16'(statusLed), 16'h0001);
    wr(CTRL_ADDR, 16'h0000);
    msgEn <= 1'b1;
    cmd(CMD_CLEAR_TIMEOUT);
    chk("clrresp", v, 16'(RESP_SUCCESS));
    cmd(CMD_READ_STATUS);
    chk("okstat", v, 16'(STATUS_NORMAL));
    wr(DO_CMD_ADDR, 16'h0011);
    repeat (2) @(posedge clk);
    chk("resume", 16'(doOut), 16'h0011);
    ce <= 1'b0;
    wr(DO_CMD_ADDR, 16'h0022);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk("cefrz", 16'(doOut), 16'h0011);
    wr(PWRON_DO_ADDR, 16'h003C);
    aliveEn <= 1'b0;
    for (int k = 0; k < 400 && moduleReboot !== 1'b1; k++) @(posedge clk);
    aliveEn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pwron", 16'(doOut), 16'h003C);
    rd(STATUS_ADDR, v);
    chk("rebootflag", 16'(v[1]), 16'h0001);
    // Power cycle, flag stored
    rst_b <= 1'b0;
    nvTimeoutIn <= 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    nvTimeoutIn <= 1'b0;
    chk("nvflag", 16'(nvTimeoutOut), 16'h0001);
    chk("nvsafe", 16'(doOut), 16'(SAFE_DO_RST));
    cmd(CMD_READ_STATUS);
    chk("nvstat", v, 16'(STATUS_TIMEOUT));
    conclude();
  end
endmodule : tb_top
